// *** cbs_pkg.sv ***
// Constants shared by the second comparator control and sync block.
package cbs_pkg;

  // ==========================================================
  // Register byte offsets on the Avalon-MM slave.
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADR_CTRL = 5'h00;
  localparam logic [4:0] ADR_SHARED = 5'h04;
  localparam logic [4:0] ADR_PORT = 5'h08;
  localparam logic [4:0] ADR_ANSEL = 5'h0C;
  localparam logic [4:0] ADR_ISTAT = 5'h10;
  localparam logic [4:0] ADR_IMASK = 5'h14;

  // ==========================================================
  // Field positions of the comparator_two_control register.
  localparam int CT_EN = 7;
  localparam int CT_RES = 6;
  localparam int CT_OE = 5;
  localparam int CT_POL = 4;
  localparam int CT_REF = 2;
  localparam int CT_CH_HI = 1;
  localparam int CT_CH_LO = 0;
  localparam logic [7:0] CT_WMASK = 8'hB7;
  localparam logic [7:0] CT_RST = 8'h00;

  // ==========================================================
  // Field positions of the comparator_shared_control register.
  localparam int SH_MIR_A = 7;
  localparam int SH_MIR_B = 6;
  localparam int SH_RSEL_A = 5;
  localparam int SH_RSEL_B = 4;
  localparam int SH_GSS = 1;
  localparam int SH_SYNC = 0;
  localparam logic [7:0] SH_WMASK = 8'h33;
  localparam logic [7:0] SH_RST = 8'h02;

  // ==========================================================
  // Port, interrupt and synchroniser constants.
  localparam int PORT_W = 8;
  localparam logic [7:0] ANSEL_RST = 8'hFF;
  localparam int IRQ_W = 2;
  localparam int IRQ_MISMATCH = 0;
  localparam int IRQ_GATE_END = 1;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam int SYNC_STAGES = 2;
  localparam int SYNC_W = 13;

  // ==========================================================
  // Bus handshake state.
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } cbs_bus_type;

endpackage

// *** cbs_sync2.sv ***
// Two-stage synchroniser for a bundle of asynchronous inputs.
`timescale 1ns/1ps
module cbs_sync2
  import cbs_pkg::*;
#(
  parameter int WIDTH = SYNC_W
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta_ff;
  logic [WIDTH-1:0] nxt_sync_ff;

  // ==========================================================
  // The first stage is read by the second stage only.
  always_comb begin
    nxt_meta_ff = meta_ff;
    nxt_sync_ff = sync_ff;
    if (i_clk_en) begin
      nxt_meta_ff = i_async;
      nxt_sync_ff = meta_ff;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta_ff;
      sync_ff <= nxt_sync_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule

// *** cbs_edge_latch.sv ***
// Falling-edge capture of a level against a sampled timer clock.
`timescale 1ns/1ps
module cbs_edge_latch (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  input wire logic i_tclk,
  input wire logic i_d,
  output logic o_q,
  output logic o_rise
);

  logic prev_ff;
  logic q_ff;
  logic rise_ff;
  logic nxt_prev_ff;
  logic nxt_q_ff;
  logic nxt_rise_ff;

  // ==========================================================
  // Capture on the falling edge; report the rising edge.
  always_comb begin
    nxt_prev_ff = prev_ff;
    nxt_q_ff = q_ff;
    nxt_rise_ff = 1'b0;
    if (i_clk_en) begin
      nxt_prev_ff = i_tclk;
      if (prev_ff && !i_tclk) begin
        nxt_q_ff = i_d;
      end
      nxt_rise_ff = !prev_ff && i_tclk;
    end else begin
      nxt_rise_ff = rise_ff;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_ff <= 1'b0;
      q_ff <= 1'b0;
      rise_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev_ff;
      q_ff <= nxt_q_ff;
      rise_ff <= nxt_rise_ff;
    end
  end

  assign o_q = q_ff;
  assign o_rise = rise_ff;

endmodule

// *** cbs_top.sv ***
// Control, output and Timer1 sync logic of the second comparator.
//
// Contract
// - Result is input comparison, inverted when invert bit set.
// - Pin drive bit 1 shows result on pin; 0 keeps it internal.
// - Pin driven only when drive, enable set and direction bit clear.
// - Two-bit channel code picks one of four shared inverting pins.
// - Port reads return 0 for every pin configured analog.
// - Gate select clear lets comparator gate a running, gate-enabled timer.
// - With sync on, result latched on each timer clock falling edge.
// - With prescaler in use, latch uses the prescaled timer clock.
// - Timer increments on rising edge, latch updates on falling edge.
// - Shared register mirrors both results for a skew-free read.
// - Mirror reads leave mismatch latches; control reads update them.
// - Sync control is bit 0 of shared register.
// - Gate select set picks external gate, clear picks synced result.
// - Mirror bits 7 and 6 are read-only and reset to 0.
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module cbs_top
  import cbs_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_clk_en,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_cmp_b_raw,
  input wire logic i_cmp_a_result,
  input wire logic [PORT_W-1:0] i_port_pins,
  input wire logic i_port_direction_bit,
  input wire logic i_tmr_clk_src,
  input wire logic i_tmr_clk_prescaled,
  input wire logic i_tmr_prescale_use,
  input wire logic i_tmr_on,
  input wire logic i_tmr_gate_enable,
  input wire logic i_ext_gate_pin,
  output logic o_cmp_b_enable,
  output logic o_cmp_b_ref_select,
  output logic [1:0] o_cmp_b_channel,
  output logic o_cmp_b_pin_out,
  output logic o_cmp_b_pin_oe,
  output logic o_synced_cmp_b_result,
  output logic o_tmr_count_enable,
  output logic o_tmr_tick,
  output logic o_irq
);

  // ==========================================================
  // Declarations.
  cbs_bus_type bus_ff;
  cbs_bus_type nxt_bus_ff;
  logic wait_ff;
  logic nxt_wait_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata_ff;
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl_ff;
  logic [7:0] shared_ff;
  logic [7:0] nxt_shared_ff;
  logic [PORT_W-1:0] ansel_ff;
  logic [PORT_W-1:0] nxt_ansel_ff;
  logic [IRQ_W-1:0] istat_ff;
  logic [IRQ_W-1:0] nxt_istat_ff;
  logic [IRQ_W-1:0] imask_ff;
  logic [IRQ_W-1:0] nxt_imask_ff;
  logic irq_ff;
  logic nxt_irq_ff;
  logic res_ff;
  logic nxt_res_ff;
  logic seen_ff;
  logic nxt_seen_ff;
  logic pin_out_ff;
  logic nxt_pin_out_ff;
  logic pin_oe_ff;
  logic nxt_pin_oe_ff;
  logic synced_ff;
  logic nxt_synced_ff;
  logic cnt_en_ff;
  logic nxt_cnt_en_ff;
  logic tick_ff;
  logic nxt_tick_ff;
  logic gate_prev_ff;
  logic nxt_gate_prev_ff;

  logic [SYNC_W-1:0] async_in;
  logic [SYNC_W-1:0] sync_in;
  logic raw_s;
  logic cmp_a_s;
  logic ext_gate_s;
  logic clk_src_s;
  logic clk_pre_s;
  logic [PORT_W-1:0] pins_s;
  logic tclk_sel;
  logic latch_q;
  logic tclk_rise;
  logic req;
  logic commit;
  logic wr_ok;
  logic gate_level;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clr;
  logic [7:0] ctrl_view;
  logic [7:0] shared_view;

  // ==========================================================
  // Pin and cross-domain inputs pass two flip-flops.
  assign async_in = {i_cmp_b_raw, i_cmp_a_result, i_ext_gate_pin,
                     i_tmr_clk_src, i_tmr_clk_prescaled, i_port_pins};

  cbs_sync2 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_clk_en(i_clk_en),
    .i_async(async_in),
    .o_sync(sync_in)
  );

  assign raw_s = sync_in[12];
  assign cmp_a_s = sync_in[11];
  assign ext_gate_s = sync_in[10];
  assign clk_src_s = sync_in[9];
  assign clk_pre_s = sync_in[8];
  assign pins_s = sync_in[PORT_W-1:0];

  // ==========================================================
  // Timer clock selection and falling-edge latch.
  // Sampling the timer clock at the system rate limits it to
  // well under half the system clock frequency.
  assign tclk_sel = i_tmr_prescale_use ? clk_pre_s : clk_src_s;

  cbs_edge_latch u_latch (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_clk_en(i_clk_en),
    .i_tclk(tclk_sel),
    .i_d(res_ff),
    .o_q(latch_q),
    .o_rise(tclk_rise)
  );

  // ==========================================================
  // Bus decode helpers.
  assign req = i_avs_read || i_avs_write;
  assign commit = req && (bus_ff == BUS_ACK);
  assign wr_ok = commit && i_avs_write && i_avs_byteenable[0];

  always_comb begin
    ctrl_view = ctrl_ff & CT_WMASK;
    ctrl_view[CT_RES] = res_ff;
    shared_view = shared_ff & SH_WMASK;
    shared_view[SH_MIR_A] = cmp_a_s;
    shared_view[SH_MIR_B] = res_ff;
  end

  // ==========================================================
  // Comparator result, pin drive and Timer1 gate.
  assign gate_level = shared_ff[SH_GSS] ? ext_gate_s : synced_ff;

  always_comb begin
    nxt_res_ff = res_ff;
    nxt_pin_out_ff = pin_out_ff;
    nxt_pin_oe_ff = pin_oe_ff;
    nxt_synced_ff = synced_ff;
    nxt_cnt_en_ff = cnt_en_ff;
    nxt_tick_ff = tick_ff;
    nxt_gate_prev_ff = gate_prev_ff;
    if (i_clk_en) begin
      if (ctrl_ff[CT_EN]) begin
        nxt_res_ff = raw_s ^ ctrl_ff[CT_POL];
      end else begin
        nxt_res_ff = 1'b0;
      end
      nxt_pin_out_ff = res_ff;
      nxt_pin_oe_ff = ctrl_ff[CT_OE] && ctrl_ff[CT_EN] &&
                      !i_port_direction_bit;
      if (shared_ff[SH_SYNC]) begin
        nxt_synced_ff = latch_q;
      end else begin
        nxt_synced_ff = res_ff;
      end
      nxt_cnt_en_ff = i_tmr_on && (!i_tmr_gate_enable || gate_level);
      nxt_tick_ff = tclk_rise && cnt_en_ff;
      nxt_gate_prev_ff = gate_level;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      res_ff <= 1'b0;
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
      synced_ff <= 1'b0;
      cnt_en_ff <= 1'b0;
      tick_ff <= 1'b0;
      gate_prev_ff <= 1'b0;
    end else begin
      res_ff <= nxt_res_ff;
      pin_out_ff <= nxt_pin_out_ff;
      pin_oe_ff <= nxt_pin_oe_ff;
      synced_ff <= nxt_synced_ff;
      cnt_en_ff <= nxt_cnt_en_ff;
      tick_ff <= nxt_tick_ff;
      gate_prev_ff <= nxt_gate_prev_ff;
    end
  end

  // ==========================================================
  // Interrupt sources.
  // A result that differs from the value last read through the
  // control register keeps setting the mismatch bit, so software
  // must read the control register before clearing it.
  always_comb begin
    events = '0;
    events[IRQ_MISMATCH] = res_ff ^ seen_ff;
    events[IRQ_GATE_END] = gate_prev_ff && !gate_level &&
                           i_tmr_gate_enable && i_tmr_on;
    clr = '0;
    if (wr_ok && (i_avs_address == ADR_ISTAT)) begin
      clr = i_avs_writedata[IRQ_W-1:0];
    end
  end

  // ==========================================================
  // Avalon-MM slave and register file.
  always_comb begin
    nxt_bus_ff = bus_ff;
    nxt_wait_ff = wait_ff;
    nxt_rdata_ff = rdata_ff;
    nxt_ctrl_ff = ctrl_ff;
    nxt_shared_ff = shared_ff;
    nxt_ansel_ff = ansel_ff;
    nxt_istat_ff = istat_ff;
    nxt_imask_ff = imask_ff;
    nxt_irq_ff = irq_ff;
    nxt_seen_ff = seen_ff;
    if (i_clk_en) begin
      case (bus_ff)
        BUS_IDLE: begin
          if (req) begin
            nxt_bus_ff = BUS_ACK;
            nxt_wait_ff = 1'b0;
            nxt_rdata_ff = 32'h0000_0000;
            if (i_avs_read) begin
              if (i_avs_address == ADR_CTRL) begin
                nxt_rdata_ff[7:0] = ctrl_view;
              end else if (i_avs_address == ADR_SHARED) begin
                nxt_rdata_ff[7:0] = shared_view;
              end else if (i_avs_address == ADR_PORT) begin
                nxt_rdata_ff[PORT_W-1:0] = pins_s & ~ansel_ff;
              end else if (i_avs_address == ADR_ANSEL) begin
                nxt_rdata_ff[PORT_W-1:0] = ansel_ff;
              end else if (i_avs_address == ADR_ISTAT) begin
                nxt_rdata_ff[IRQ_W-1:0] = istat_ff;
              end else if (i_avs_address == ADR_IMASK) begin
                nxt_rdata_ff[IRQ_W-1:0] = imask_ff;
              end
            end
          end else begin
            nxt_wait_ff = 1'b1;
          end
        end
        BUS_ACK: begin
          nxt_bus_ff = BUS_IDLE;
          nxt_wait_ff = 1'b1;
          if (commit && i_avs_read && (i_avs_address == ADR_CTRL)) begin
            nxt_seen_ff = res_ff;
          end
          if (wr_ok) begin
            if (i_avs_address == ADR_CTRL) begin
              nxt_ctrl_ff = i_avs_writedata[7:0] & CT_WMASK;
            end else if (i_avs_address == ADR_SHARED) begin
              nxt_shared_ff = i_avs_writedata[7:0] & SH_WMASK;
            end else if (i_avs_address == ADR_ANSEL) begin
              nxt_ansel_ff = i_avs_writedata[PORT_W-1:0];
            end else if (i_avs_address == ADR_IMASK) begin
              nxt_imask_ff = i_avs_writedata[IRQ_W-1:0];
            end
          end
        end
        default: begin
          nxt_bus_ff = BUS_IDLE;
          nxt_wait_ff = 1'b1;
        end
      endcase
      // A new event wins over a clear written in the same cycle.
      nxt_istat_ff = (istat_ff & ~clr) | events;
      nxt_irq_ff = |(nxt_istat_ff & nxt_imask_ff);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bus_ff <= BUS_IDLE;
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0000_0000;
      ctrl_ff <= CT_RST;
      shared_ff <= SH_RST;
      ansel_ff <= ANSEL_RST;
      istat_ff <= IRQ_RST;
      imask_ff <= IRQ_RST;
      irq_ff <= 1'b0;
      seen_ff <= 1'b0;
    end else begin
      bus_ff <= nxt_bus_ff;
      wait_ff <= nxt_wait_ff;
      rdata_ff <= nxt_rdata_ff;
      ctrl_ff <= nxt_ctrl_ff;
      shared_ff <= nxt_shared_ff;
      ansel_ff <= nxt_ansel_ff;
      istat_ff <= nxt_istat_ff;
      imask_ff <= nxt_imask_ff;
      irq_ff <= nxt_irq_ff;
      seen_ff <= nxt_seen_ff;
    end
  end

  // ==========================================================
  // Outputs, each taken from a flip-flop.
  assign o_avs_readdata = rdata_ff;
  assign o_avs_waitrequest = wait_ff;
  assign o_cmp_b_enable = ctrl_ff[CT_EN];
  assign o_cmp_b_ref_select = ctrl_ff[CT_REF];
  assign o_cmp_b_channel = ctrl_ff[CT_CH_HI:CT_CH_LO];
  assign o_cmp_b_pin_out = pin_out_ff;
  assign o_cmp_b_pin_oe = pin_oe_ff;
  assign o_synced_cmp_b_result = synced_ff;
  assign o_tmr_count_enable = cnt_en_ff;
  assign o_tmr_tick = tick_ff;
  assign o_irq = irq_ff;

endmodule

// *** cbs_chk.sv ***
// Assertion checker on the ports of the second comparator block.
`timescale 1ns/1ps
module cbs_chk
  import cbs_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_port_direction_bit,
  input wire logic i_tmr_on,
  input wire logic i_tmr_gate_enable,
  input wire logic o_cmp_b_enable,
  input wire logic o_cmp_b_ref_select,
  input wire logic [1:0] o_cmp_b_channel,
  input wire logic o_cmp_b_pin_out,
  input wire logic o_cmp_b_pin_oe,
  input wire logic o_tmr_count_enable,
  input wire logic o_tmr_tick
);
  // ==========================================================
  // Bus handshake, pin gating and timer output checks.
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  property p_wait_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low too long");
  property p_wait_req; !o_avs_waitrequest |-> $past(i_avs_read || i_avs_write); endproperty
  a_wait_req: assert property (p_wait_req) else $error("answer without request");
  property p_oe; o_cmp_b_pin_oe |-> $past(o_cmp_b_enable && !i_port_direction_bit); endproperty
  a_oe: assert property (p_oe) else $error("pin driven while not allowed");
  property p_pin_off; !o_cmp_b_enable [*2] |=> !o_cmp_b_pin_out; endproperty
  a_pin_off: assert property (p_pin_off) else $error("result on while off");
  property p_ctrl_hold;
    $changed({o_cmp_b_enable, o_cmp_b_ref_select, o_cmp_b_channel}) |->
      $past(i_avs_write && !o_avs_waitrequest && i_avs_address == ADR_CTRL);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control moved alone");
  property p_count_off; !i_tmr_on |=> !o_tmr_count_enable; endproperty
  a_count_off: assert property (p_count_off) else $error("count while off");
  property p_count_free; i_tmr_on && !i_tmr_gate_enable |=> o_tmr_count_enable; endproperty
  a_count_free: assert property (p_count_free) else $error("ungated not counting");
  property p_tick_cause; o_tmr_tick |-> $past(o_tmr_count_enable); endproperty
  a_tick_cause: assert property (p_tick_cause) else $error("tick while gated");
  property p_tick_single; o_tmr_tick |=> !o_tmr_tick; endproperty
  a_tick_single: assert property (p_tick_single) else $error("tick too long");
endmodule

// *** cbs_tmr_model.sv ***
// Timer clock source and tick counter beside the comparator block.
`timescale 1ns/1ps
module cbs_tmr_model (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_run,
  input wire logic i_run_pre,
  input wire logic i_tick,
  output logic o_clk_src,
  output logic o_clk_pre,
  output int o_rises,
  output int o_ticks
);
  // ==========================================================
  // Clocks stand still while stopped, so no stray edge reaches the latch.
  logic [2:0] div_ff;
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_ff <= 3'h0;
      o_clk_pre <= 1'b0;
      o_rises <= 0;
      o_ticks <= 0;
    end else begin
      if (i_run) begin
        div_ff <= div_ff + 3'h1;
      end
      if (i_run && div_ff[1:0] == 2'h1) begin
        o_rises <= o_rises + 1;
      end
      if (i_run && i_run_pre && div_ff == 3'h7) begin
        o_clk_pre <= !o_clk_pre;
      end
      o_ticks <= o_ticks + int'(i_tick);
    end
  end
  assign o_clk_src = div_ff[1];
endmodule

// *** tb_top.sv ***
// Self-checking testbench of the second comparator block.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("ERROR at %0t: got %0h expected %0h", $time, a, e); end end
module tb_top
  import cbs_pkg::*;
;
  logic i_sys_clk, i_rstn, i_clk_en, i_avs_read, i_avs_write, o_avs_waitrequest;
  logic [ADDR_W-1:0] i_avs_address;
  logic [31:0] i_avs_writedata, o_avs_readdata;
  logic [3:0] i_avs_byteenable;
  logic i_cmp_b_raw, i_cmp_a_result, i_port_direction_bit, i_tmr_clk_src, i_tmr_clk_prescaled;
  logic [PORT_W-1:0] i_port_pins;
  logic i_tmr_prescale_use, i_tmr_on, i_tmr_gate_enable, i_ext_gate_pin, o_irq, o_tmr_tick;
  logic o_cmp_b_enable, o_cmp_b_ref_select, o_cmp_b_pin_out, o_cmp_b_pin_oe;
  logic o_synced_cmp_b_result, o_tmr_count_enable, run, run_pre;
  logic [1:0] o_cmp_b_channel;
  int rises, ticks, errors, n_compared, r0, t0;
  cbs_top u_dut (.*);
  cbs_tmr_model u_tmr (.i_sys_clk, .i_rstn, .i_run(run), .i_run_pre(run_pre),
    .i_tick(o_tmr_tick), .o_clk_src(i_tmr_clk_src), .o_clk_pre(i_tmr_clk_prescaled),
    .o_rises(rises), .o_ticks(ticks));
  // ==========================================================
  // Bus master: holds the request until waitrequest is sampled low.
  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
      output logic [7:0] q);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    i_avs_address <= a;
    i_avs_write <= w;
    i_avs_read <= !w;
    i_avs_writedata <= {24'h00_0000, d};
    do begin @(posedge i_sys_clk); n++; end while (o_avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      errors++;
      $display("ERROR at %0t: bus timeout", $time);
    end
    q = o_avs_readdata[7:0];
    `CHK(o_avs_readdata[31:8], 24'h00_0000)
    i_avs_write <= 1'b0;
    i_avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask
  // ==========================================================
  // Scenarios.
  task automatic t_ctrl;
    rdc(ADR_CTRL, CT_RST);
    rdc(ADR_SHARED, SH_RST);
    rdc(ADR_ANSEL, ANSEL_RST);
    wr(ADR_CTRL, 8'hBF);
    wr(5'h1C, 8'hFF);
    cyc(6);
    rdc(ADR_CTRL, 8'hF7);
    rdc(5'h1C, 8'h00);
    wr(ADR_SHARED, 8'hFF);
    rdc(ADR_SHARED, 8'h73);
    for (int k = 0; k < 4; k++) begin
      wr(ADR_CTRL, 8'h80 | 8'(k));
      cyc(1);
      `CHK(o_cmp_b_channel, 2'(k))
      `CHK(o_cmp_b_ref_select, 1'b0)
    end
    wr(ADR_CTRL, 8'h04);
    cyc(1);
    `CHK(o_cmp_b_ref_select, 1'b1)
    `CHK(o_cmp_b_enable, 1'b0)
    i_avs_byteenable <= 4'h0;
    wr(ADR_CTRL, 8'hFF);
    i_avs_byteenable <= 4'h1;
    rdc(ADR_CTRL, 8'h04);
    $display("t_ctrl done");
  endtask
  task automatic t_pol;
    wr(ADR_SHARED, 8'h02);
    for (int k = 0; k < 4; k++) begin
      i_cmp_b_raw <= k[0];
      i_cmp_a_result <= k[1];
      wr(ADR_CTRL, {3'b100, k[1], 4'h0});
      cyc(6);
      rdc(ADR_CTRL, {1'b1, k[0] ^ k[1], 1'b0, k[1], 4'h0});
      rdc(ADR_SHARED, {k[1], k[0] ^ k[1], 6'h02});
    end
    wr(ADR_CTRL, 8'h10);
    cyc(6);
    rdc(ADR_CTRL, 8'h10);
    i_cmp_a_result <= 1'b0;
    $display("t_pol done");
  endtask
  task automatic t_pin;
    i_cmp_b_raw <= 1'b1;
    wr(ADR_CTRL, 8'hA0);
    cyc(6);
    `CHK(o_cmp_b_pin_oe, 1'b1)
    `CHK(o_cmp_b_pin_out, 1'b1)
    i_cmp_b_raw <= 1'b0;
    cyc(6);
    `CHK(o_cmp_b_pin_out, 1'b0)
    i_clk_en <= 1'b0;
    i_cmp_b_raw <= 1'b1;
    cyc(8);
    `CHK(o_cmp_b_pin_out, 1'b0)
    i_clk_en <= 1'b1;
    cyc(6);
    `CHK(o_cmp_b_pin_out, 1'b1)
    i_cmp_b_raw <= 1'b0;
    cyc(6);
    i_port_direction_bit <= 1'b1;
    cyc(3);
    `CHK(o_cmp_b_pin_oe, 1'b0)
    i_port_direction_bit <= 1'b0;
    wr(ADR_CTRL, 8'h80);
    cyc(3);
    `CHK(o_cmp_b_pin_oe, 1'b0)
    i_port_pins <= 8'hA5;
    wr(ADR_ANSEL, 8'h0F);
    cyc(4);
    rdc(ADR_PORT, 8'hA0);
    wr(ADR_ANSEL, 8'hFF);
    rdc(ADR_PORT, 8'h00);
    $display("t_pin done");
  endtask
  task automatic t_irq;
    wr(ADR_IMASK, 8'h01);
    rdc(ADR_CTRL, 8'h80);
    wr(ADR_ISTAT, 8'h03);
    cyc(3);
    `CHK(o_irq, 1'b0)
    i_cmp_b_raw <= 1'b1;
    cyc(6);
    `CHK(o_irq, 1'b1)
    rdc(ADR_SHARED, 8'h42);
    wr(ADR_ISTAT, 8'h01);
    cyc(3);
    `CHK(o_irq, 1'b1)
    rdc(ADR_CTRL, 8'hC0);
    wr(ADR_ISTAT, 8'h01);
    cyc(3);
    `CHK(o_irq, 1'b0)
    i_cmp_b_raw <= 1'b0;
    cyc(6);
    wr(ADR_IMASK, 8'h00);
    cyc(3);
    `CHK(o_irq, 1'b0)
    rdc(ADR_ISTAT, 8'h01);
    $display("t_irq done");
  endtask
  task automatic t_gate;
    i_cmp_b_raw <= 1'b1;
    wr(ADR_SHARED, 8'h00);
    i_tmr_on <= 1'b1;
    i_tmr_gate_enable <= 1'b1;
    run <= 1'b1;
    cyc(30);
    `CHK(o_tmr_count_enable, 1'b1)
    i_cmp_b_raw <= 1'b0;
    cyc(8);
    `CHK(o_tmr_count_enable, 1'b0)
    wr(ADR_SHARED, 8'h02);
    i_ext_gate_pin <= 1'b1;
    cyc(6);
    `CHK(o_tmr_count_enable, 1'b1)
    i_ext_gate_pin <= 1'b0;
    cyc(6);
    `CHK(o_tmr_count_enable, 1'b0)
    i_tmr_gate_enable <= 1'b0;
    run <= 1'b0;
    cyc(10);
    r0 = rises;
    t0 = ticks;
    run <= 1'b1;
    cyc(40);
    run <= 1'b0;
    cyc(10);
    `CHK(ticks - t0, rises - r0)
    `CHK(rises - r0, 10)
    rdc(ADR_ISTAT, 8'h03);
    wr(ADR_ISTAT, 8'h02);
    rdc(ADR_ISTAT, 8'h01);
    i_tmr_on <= 1'b0;
    $display("t_gate done");
  endtask
  task automatic t_sync;
    wr(ADR_SHARED, 8'h01);
    i_cmp_b_raw <= 1'b1;
    run <= 1'b1;
    cyc(20);
    `CHK(o_synced_cmp_b_result, 1'b1)
    run <= 1'b0;
    cyc(4);
    i_cmp_b_raw <= 1'b0;
    cyc(10);
    `CHK(o_synced_cmp_b_result, 1'b1)
    run <= 1'b1;
    cyc(20);
    `CHK(o_synced_cmp_b_result, 1'b0)
    i_tmr_prescale_use <= 1'b1;
    i_cmp_b_raw <= 1'b1;
    cyc(20);
    `CHK(o_synced_cmp_b_result, 1'b0)
    run_pre <= 1'b1;
    cyc(40);
    `CHK(o_synced_cmp_b_result, 1'b1)
    run <= 1'b0;
    i_cmp_b_raw <= 1'b0;
    wr(ADR_SHARED, 8'h00);
    cyc(6);
    `CHK(o_synced_cmp_b_result, 1'b0)
    $display("t_sync done");
  endtask
  // ==========================================================
  // Clock, reset, sequence and verdict.
  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = !i_sys_clk;
  end
  initial begin
    {i_rstn, i_avs_read, i_avs_write, i_cmp_b_raw, i_cmp_a_result, i_port_direction_bit} = '0;
    {i_tmr_prescale_use, i_tmr_on, i_tmr_gate_enable, i_ext_gate_pin, run, run_pre} = '0;
    i_clk_en = 1'b1;
    i_avs_address = '0;
    i_avs_writedata = '0;
    i_avs_byteenable = 4'h1;
    i_port_pins = '0;
    errors = 0;
    n_compared = 0;
    cyc(10);
    i_rstn <= 1'b1;
    t_ctrl();
    t_pol();
    t_pin();
    t_irq();
    t_gate();
    t_sync();
    summarize();
  end
  initial begin
    #200_000;
    errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    summarize();
  end
endmodule
bind cbs_top cbs_chk u_chk (.*);
